// >>> logic/cfg_if.sv
// Purpose: Carries live configuration between the guard modules
// Assumes: One clock domain
// Notes: Owner holds the register and its shadow
`include "pmwg_consts.svh"
interface cfg_if;
    pmwg_pkg::cfg_s cfg;
    pmwg_pkg::cfg_s load_val;
    logic load;
    logic inject_en;
    logic [`PMWG_CFG_W-1:0] inject;
    logic mismatch;
    modport owner (input load, load_val, inject_en, inject, output cfg, mismatch);
    modport ctl (output load, load_val, inject_en, inject, input cfg, mismatch);
    modport user (input cfg);
endinterface

// >>> logic/config_shadow.sv
// Purpose: Configuration register with complementary shadow copy
// Assumes: Loaded from the stored configuration word
// Notes: Inject flips shadow bits to exercise the fault path
`include "pmwg_consts.svh"
module config_shadow (
    input wire logic clk_i,
    input wire logic rst_n_i,
    cfg_if.owner c
);
    pmwg_pkg::cfg_s cfg;
    logic [`PMWG_CFG_W-1:0] shadow;
    pmwg_pkg::cfg_s next_cfg;
    logic [`PMWG_CFG_W-1:0] next_shadow;
    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_cfg = cfg;
        next_shadow = shadow;
        if (c.load) begin
            next_cfg = c.load_val;
            next_shadow = ~c.load_val;
        end else if (c.inject_en) begin
            next_shadow = shadow ^ c.inject;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg <= `PMWG_CFG_ERASED;
            shadow <= ~`PMWG_CFG_ERASED;
        end else begin
            cfg <= next_cfg;
            shadow <= next_shadow;
        end
    end
    // Compared every cycle, not only on load
    assign c.mismatch = (cfg != ~shadow);
    assign c.cfg = cfg;
endmodule

// >>> logic/pmwg_consts.svh
// Purpose: Constants for the program memory write guard
// Assumes: Word addressed program memory, 512-word pages
// Notes: Config field values use the erased-flash sense (0 = programmed)
`ifndef PMWG_CONSTS_SVH
`define PMWG_CONSTS_SVH
// ----------------------------------------
// Widths and memory geometry
// ----------------------------------------
`define PMWG_CFG_W 13
`define PMWG_ADDR_W 17
`define PMWG_PAGE_MSB 16
`define PMWG_PAGE_LSB 9
`define PMWG_LAST_PAGE 8'hFF
`define PMWG_CFG_ERASED 13'h1FFF
`define PMWG_PROG 1'b0
`define PMWG_DENY_MAX 16'hFFFF
// ----------------------------------------
// Register offsets and bit positions
// ----------------------------------------
`define PMWG_OFF_CFG 12'h000
`define PMWG_OFF_STATUS 12'h004
`define PMWG_OFF_CTRL 12'h008
`define PMWG_OFF_INJECT 12'h00C
`define PMWG_OFF_DENYCNT 12'h010
`define PMWG_ST_NVM_DEN 0
`define PMWG_ST_EXT_DEN 1
`define PMWG_ST_PARITY 2
`define PMWG_ST_LOADED 3
`define PMWG_CTRL_RELOAD 0
`endif

// >>> logic/pmwg_pkg.sv
// Purpose: Shared types of the program memory write guard
// Assumes: Constants come from pmwg_consts.svh
// Notes: Struct field order matches the stored configuration word
`include "pmwg_consts.svh"
package pmwg_pkg;
    typedef struct packed {
        logic global_read_write_protect;
        logic global_write_protect;
        logic segment_protect_disable;
        logic segment_boundary_direction;
        logic last_page_protect;
        logic [7:0] segment_page_pointer;
    } cfg_s;
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN = 2'b01,
        ST_FAULT = 2'b10
    } state_e;
endpackage

// >>> logic/program_memory_write_guard.sv
// Purpose: Guards program memory writes, erases and external access
// Assumes: Requesters and APB master run on CLK_SYS_I
// Notes: Instruction fetch is never gated by this block
`include "pmwg_consts.svh"
module program_memory_write_guard (
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [`PMWG_CFG_W-1:0] CFG_WORD_I,
    input wire logic NVM_REQ_I,
    input wire logic NVM_ERASE_I,
    input wire logic [`PMWG_ADDR_W-1:0] NVM_ADDR_I,
    output logic NVM_GRANT_O,
    output logic NVM_DENY_O,
    output logic NVM_ERASE_O,
    input wire logic EXT_REQ_I,
    input wire logic EXT_WR_I,
    input wire logic [`PMWG_ADDR_W-1:0] EXT_ADDR_I,
    output logic EXT_GRANT_O,
    output logic EXT_DENY_O,
    output logic [`PMWG_ADDR_W-1:0] EXT_ADDR_O,
    output logic PARITY_ERR_O,
    output logic DEV_RST_REQ_O
);
    cfg_if cif();
    pmwg_pkg::state_e state;
    pmwg_pkg::state_e next_state;
    logic nvm_blocked;
    logic run_ok;
    logic ext_ok;
    logic nvm_grant;
    logic nvm_deny;
    logic nvm_erase;
    logic ext_grant;
    logic ext_deny;
    logic [`PMWG_ADDR_W-1:0] ext_addr;
    logic next_nvm_grant;
    logic next_nvm_deny;
    logic next_nvm_erase;
    logic next_ext_grant;
    logic next_ext_deny;
    logic [`PMWG_ADDR_W-1:0] next_ext_addr;
    logic parity;
    logic loaded;
    logic nvm_den;
    logic ext_den;
    logic [15:0] deny_cnt;
    logic next_parity;
    logic next_loaded;
    logic next_nvm_den;
    logic next_ext_den;
    logic [15:0] next_deny_cnt;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [31:0] rd_mux;
    logic mapped;
    logic wr_en;
    logic wr_status;
    logic wr_ctrl;
    logic wr_inject;
    logic reload;
    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    config_shadow u_shadow (
        .clk_i(CLK_SYS_I),
        .rst_n_i(NRST_I),
        .c(cif.owner)
    );
    seg_range u_range (
        .c(cif.user),
        .addr_i(NVM_ADDR_I),
        .blocked_o(nvm_blocked)
    );
    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (PADDR_I)
            `PMWG_OFF_CFG: begin
                rd_mux = 32'(cif.cfg);
            end
            `PMWG_OFF_STATUS: begin
                rd_mux[`PMWG_ST_NVM_DEN] = nvm_den;
                rd_mux[`PMWG_ST_EXT_DEN] = ext_den;
                rd_mux[`PMWG_ST_PARITY] = parity;
                rd_mux[`PMWG_ST_LOADED] = loaded;
            end
            `PMWG_OFF_CTRL: begin
                rd_mux = 32'h0000_0000;
            end
            `PMWG_OFF_INJECT: begin
                rd_mux = 32'h0000_0000;
            end
            `PMWG_OFF_DENYCNT: begin
                rd_mux = 32'(deny_cnt);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end
    // Zero wait states: every access completes in its first access cycle
    assign PREADY_O = PSEL_I & PENABLE_I;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
    assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & mapped;
    assign wr_status = wr_en && (PADDR_I == `PMWG_OFF_STATUS);
    assign wr_ctrl = wr_en && (PADDR_I == `PMWG_OFF_CTRL);
    assign wr_inject = wr_en && (PADDR_I == `PMWG_OFF_INJECT);
    assign reload = wr_ctrl && PWDATA_I[`PMWG_CTRL_RELOAD];
    // Read data is captured in the setup cycle so it leaves a flip-flop
    always_comb begin
        next_rdata = rdata;
        if (PSEL_I && !PENABLE_I) begin
            next_rdata = PWRITE_I ? 32'h0000_0000 : rd_mux;
        end
    end
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end
    assign PRDATA_O = rdata;
    // ----------------------------------------
    // Config load and fault control
    // ----------------------------------------
    always_comb begin
        cif.load = 1'b0;
        cif.load_val = pmwg_pkg::cfg_s'(CFG_WORD_I);
        cif.inject_en = 1'b0;
        cif.inject = PWDATA_I[`PMWG_CFG_W-1:0];
        next_state = state;
        case (state)
            pmwg_pkg::ST_LOAD: begin
                cif.load = 1'b1;
                next_state = pmwg_pkg::ST_RUN;
            end
            pmwg_pkg::ST_RUN: begin
                if (cif.mismatch) begin
                    next_state = pmwg_pkg::ST_FAULT;
                end else if (reload) begin
                    cif.load = 1'b1;
                end else begin
                    cif.inject_en = wr_inject;
                end
            end
            pmwg_pkg::ST_FAULT: begin
                // Held until the device reset clears everything
                next_state = pmwg_pkg::ST_FAULT;
            end
            default: begin
                next_state = pmwg_pkg::ST_FAULT;
            end
        endcase
    end
    // ----------------------------------------
    // Access decisions
    // ----------------------------------------
    // A mismatching config may be corrupt, so nothing is granted on it
    assign run_ok = (state == pmwg_pkg::ST_RUN) && !cif.mismatch;
    // Code protect covers the whole memory, config words included
    assign ext_ok = run_ok
        && (cif.cfg.global_read_write_protect != `PMWG_PROG);
    always_comb begin
        next_nvm_grant = NVM_REQ_I && run_ok && !nvm_blocked;
        next_nvm_deny = NVM_REQ_I && !(run_ok && !nvm_blocked);
        next_nvm_erase = NVM_REQ_I && NVM_ERASE_I && next_nvm_grant;
        next_ext_grant = EXT_REQ_I && ext_ok;
        next_ext_deny = EXT_REQ_I && !ext_ok;
        next_ext_addr = ext_addr;
        if (next_ext_grant) begin
            next_ext_addr = EXT_ADDR_I;
        end
    end
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state <= pmwg_pkg::ST_LOAD;
            nvm_grant <= 1'b0;
            nvm_deny <= 1'b0;
            nvm_erase <= 1'b0;
            ext_grant <= 1'b0;
            ext_deny <= 1'b0;
            ext_addr <= '0;
        end else begin
            state <= next_state;
            nvm_grant <= next_nvm_grant;
            nvm_deny <= next_nvm_deny;
            nvm_erase <= next_nvm_erase;
            ext_grant <= next_ext_grant;
            ext_deny <= next_ext_deny;
            ext_addr <= next_ext_addr;
        end
    end
    // Grant is the interlock enable; a denied request never reaches the array
    assign NVM_GRANT_O = nvm_grant;
    assign NVM_DENY_O = nvm_deny;
    assign NVM_ERASE_O = nvm_erase;
    assign EXT_GRANT_O = ext_grant;
    assign EXT_DENY_O = ext_deny;
    assign EXT_ADDR_O = ext_addr;
    // ----------------------------------------
    // Status flags and counter
    // ----------------------------------------
    always_comb begin
        next_parity = parity | (cif.mismatch && state != pmwg_pkg::ST_LOAD);
        next_loaded = loaded | (state == pmwg_pkg::ST_LOAD);
        // Set wins over a clear in the same cycle
        next_nvm_den = next_nvm_deny
            | (nvm_den & ~(wr_status & PWDATA_I[`PMWG_ST_NVM_DEN]));
        next_ext_den = next_ext_deny
            | (ext_den & ~(wr_status & PWDATA_I[`PMWG_ST_EXT_DEN]));
        next_deny_cnt = deny_cnt;
        if ((next_nvm_deny || next_ext_deny) && deny_cnt != `PMWG_DENY_MAX) begin
            next_deny_cnt = deny_cnt + 16'h0001;
        end
    end
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            parity <= 1'b0;
            loaded <= 1'b0;
            nvm_den <= 1'b0;
            ext_den <= 1'b0;
            deny_cnt <= 16'h0000;
        end else begin
            parity <= next_parity;
            loaded <= next_loaded;
            nvm_den <= next_nvm_den;
            ext_den <= next_ext_den;
            deny_cnt <= next_deny_cnt;
        end
    end
    assign PARITY_ERR_O = parity;
    // Reset request stays high until the system reset lands on NRST_I
    assign DEV_RST_REQ_O = parity;
endmodule

// >>> logic/seg_range.sv
// Purpose: Decides whether a write or erase address is protected
// Assumes: Boundaries are page aligned, so erase checks one address
// Notes: Purely combinational
`include "pmwg_consts.svh"
module seg_range (
    cfg_if.user c,
    input wire logic [`PMWG_ADDR_W-1:0] addr_i,
    output logic blocked_o
);
    logic [7:0] page;
    logic seg_on;
    logic in_seg;
    logic cfg_page;
    always_comb begin
        page = addr_i[`PMWG_PAGE_MSB:`PMWG_PAGE_LSB];
        seg_on = (c.cfg.segment_protect_disable == `PMWG_PROG);
        if (c.cfg.segment_boundary_direction == `PMWG_PROG) begin
            in_seg = (page <= c.cfg.segment_page_pointer);
        end else begin
            // Runs to the last page, so the config words are always in
            in_seg = (page >= c.cfg.segment_page_pointer);
        end
        cfg_page = (page == `PMWG_LAST_PAGE)
            && (c.cfg.last_page_protect == `PMWG_PROG);
        // Segment only adds to the global write protect
        blocked_o = (c.cfg.global_write_protect == `PMWG_PROG)
            || (seg_on && (in_seg || cfg_page));
    end
endmodule

// >>> verification/pmwg_asserts.sv
// Purpose: Port-level checks of the write guard
// Assumes: One clock, NRST_I async active low
// Notes: Bound to the top module at the foot
`include "pmwg_consts.svh"
module pmwg_checker (
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic NVM_REQ_I,
    input wire logic NVM_ERASE_I,
    input wire logic NVM_GRANT_O,
    input wire logic NVM_DENY_O,
    input wire logic NVM_ERASE_O,
    input wire logic EXT_REQ_I,
    input wire logic [`PMWG_ADDR_W-1:0] EXT_ADDR_I,
    input wire logic EXT_GRANT_O,
    input wire logic EXT_DENY_O,
    input wire logic [`PMWG_ADDR_W-1:0] EXT_ADDR_O,
    input wire logic PARITY_ERR_O,
    input wire logic DEV_RST_REQ_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);
    a_nvm_one_answer: assert property (NVM_REQ_I |=> NVM_GRANT_O != NVM_DENY_O)
        else $error("internal request not answered once");
    a_nvm_no_stray: assert property (!NVM_REQ_I |=> !(NVM_GRANT_O || NVM_DENY_O))
        else $error("answer without request");
    a_erase_granted: assert property (NVM_ERASE_O |-> NVM_GRANT_O && $past(NVM_ERASE_I))
        else $error("erase out without granted erase");
    a_ext_one_answer: assert property (EXT_REQ_I |=> EXT_GRANT_O != EXT_DENY_O)
        else $error("external request not answered once");
    a_ext_addr_pass: assert property (EXT_GRANT_O |-> EXT_ADDR_O == $past(EXT_ADDR_I))
        else $error("external address not passed");
    a_fault_denies: assert property (PARITY_ERR_O && NVM_REQ_I |=> NVM_DENY_O)
        else $error("request granted during fault");
    a_reset_req_level: assert property (DEV_RST_REQ_O == PARITY_ERR_O)
        else $error("reset request differs from parity");
    a_parity_sticky: assert property (PARITY_ERR_O |=> PARITY_ERR_O [*3])
        else $error("parity error dropped");
    a_inject_fault: assert property (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 12'h00C
        && PWDATA_I[12:0] != 13'h0000 |-> ##[1:2] PARITY_ERR_O)
        else $error("shadow mismatch not flagged");
    a_pready_zero_wait: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
        else $error("bus access stalled");
    c_erase_grant: cover property (NVM_GRANT_O && NVM_ERASE_O);
    c_ext_deny: cover property (EXT_DENY_O);
    c_fault: cover property ($rose(PARITY_ERR_O));
endmodule
bind program_memory_write_guard pmwg_checker chk_u (.*);

// >>> verification/prog_agent.sv
// Purpose: Requester model for internal and external program access
// Assumes: One request at a time, answer one cycle later
// Notes: Released lines show the inverse of the last value
module prog_agent (
    input wire logic clk_i,
    input wire logic nvm_grant_i,
    input wire logic nvm_deny_i,
    input wire logic nvm_erase_i,
    input wire logic ext_grant_i,
    input wire logic ext_deny_i,
    output logic nvm_req_o = 1'b0,
    output logic nvm_erase_req_o = 1'b0,
    output logic [16:0] nvm_addr_o = 17'h0_0000,
    output logic ext_req_o = 1'b0,
    output logic ext_wr_o = 1'b0,
    output logic [16:0] ext_addr_o = 17'h0_0000
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic nvm_op(input logic [16:0] a, input logic e, output logic [2:0] r);
        @(posedge clk_i);
        nvm_req_o <= 1'b1;
        nvm_addr_o <= a;
        nvm_erase_req_o <= e;
        @(posedge clk_i);
        nvm_req_o <= 1'b0;
        nvm_addr_o <= ~a;
        nvm_erase_req_o <= ~e;
        #1 r = {nvm_grant_i, nvm_deny_i, nvm_erase_i};
    endtask
    task automatic ext_op(input logic [16:0] a, input logic w, output logic [1:0] r);
        @(posedge clk_i);
        ext_req_o <= 1'b1;
        ext_addr_o <= a;
        ext_wr_o <= w;
        @(posedge clk_i);
        ext_req_o <= 1'b0;
        ext_addr_o <= ~a;
        ext_wr_o <= ~w;
        #1 r = {ext_grant_i, ext_deny_i};
    endtask
endmodule

// >>> verification/program_memory_write_guard_tb_top.sv
// Purpose: Self-checking bench of the write guard
// Assumes: Zero-wait bus, one-cycle answers
// Notes: Each row reloads the stored word before probing
module program_memory_write_guard_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [12:0] cfg; logic [16:0] addr; logic er; logic dn;} row_s;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [12:0] cfg_word = 13'h1FFF;
    logic [31:0] prdata;
    logic pready, pslverr, nreq, nerase, grant, deny, erase_o, ereq, ewr, egrant, edeny;
    logic parity, dev_rst;
    logic [16:0] naddr, eaddr, eaddr_o;
    int failures = 0, checks_done = 0, cycles = 0, exp_den = 0;
    row_s rows [12] = '{
        '{13'h1910, 17'h0_21FF, 1'b0, 1'b1}, '{13'h1910, 17'h0_2200, 1'b1, 1'b0},
        '{13'h1910, 17'h1_FE00, 1'b0, 1'b0}, '{13'h1810, 17'h1_FFFF, 1'b0, 1'b1},
        '{13'h1B80, 17'h0_FFFF, 1'b0, 1'b0}, '{13'h1B80, 17'h1_0000, 1'b1, 1'b1},
        '{13'h1B80, 17'h1_FFFF, 1'b0, 1'b1}, '{13'h1C10, 17'h0_0000, 1'b1, 1'b0},
        '{13'h1110, 17'h1_0000, 1'b0, 1'b1}, '{13'h17FF, 17'h0_0000, 1'b0, 1'b1},
        '{13'h0FFF, 17'h1_FFFF, 1'b1, 1'b0}, '{13'h0B80, 17'h1_0000, 1'b0, 1'b1}};
    always #12.5 clk = ~clk;
    program_memory_write_guard dut_u (.CLK_SYS_I(clk), .NRST_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .CFG_WORD_I(cfg_word),
        .NVM_REQ_I(nreq), .NVM_ERASE_I(nerase), .NVM_ADDR_I(naddr), .NVM_GRANT_O(grant),
        .NVM_DENY_O(deny), .NVM_ERASE_O(erase_o), .EXT_REQ_I(ereq), .EXT_WR_I(ewr),
        .EXT_ADDR_I(eaddr), .EXT_GRANT_O(egrant), .EXT_DENY_O(edeny), .EXT_ADDR_O(eaddr_o),
        .PARITY_ERR_O(parity), .DEV_RST_REQ_O(dev_rst));
    prog_agent ag_u (.clk_i(clk), .nvm_grant_i(grant), .nvm_deny_i(deny),
        .nvm_erase_i(erase_o), .ext_grant_i(egrant), .ext_deny_i(edeny), .nvm_req_o(nreq),
        .nvm_erase_req_o(nerase), .nvm_addr_o(naddr), .ext_req_o(ereq), .ext_wr_o(ewr),
        .ext_addr_o(eaddr));
    task automatic conclude();
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reload(input logic [12:0] w);
        logic [31:0] rd;
        logic e;
        @(posedge clk);
        cfg_word <= w;
        apb(1'b1, 12'h008, 32'h0000_0001, rd, e);
        apb(1'b0, 12'h000, 32'h0000_0000, rd, e);
        chk(rd, {19'h0_0000, w});
    endtask
    task automatic s_start();
        logic [31:0] rd;
        logic e;
        apb(1'b0, 12'h000, 32'h0000_0000, rd, e);
        chk(rd, 32'h0000_1FFF);
        apb(1'b0, 12'h020, 32'h0000_0000, rd, e);
        chk({31'h0000_0000, e}, 32'h0000_0001);
    endtask
    task automatic s_table();
        logic [2:0] r;
        logic [1:0] x;
        foreach (rows[i]) begin
            reload(rows[i].cfg);
            ag_u.nvm_op(rows[i].addr, rows[i].er, r);
            chk({29'h0, r}, {29'h0, !rows[i].dn, rows[i].dn, rows[i].er & !rows[i].dn});
            ag_u.ext_op(rows[i].addr, rows[i].er, x);
            chk({30'h0, x}, {30'h0, rows[i].cfg[12], !rows[i].cfg[12]});
            if (rows[i].cfg[12]) begin
                chk({15'h0000, eaddr_o}, {15'h0000, rows[i].addr});
            end
            exp_den += int'(rows[i].dn) + int'(!rows[i].cfg[12]);
        end
    endtask
    task automatic s_status();
        logic [31:0] rd;
        logic e;
        apb(1'b0, 12'h010, 32'h0000_0000, rd, e);
        chk(rd, 32'(exp_den));
        apb(1'b0, 12'h004, 32'h0000_0000, rd, e);
        chk(rd, 32'h0000_000B);
        apb(1'b1, 12'h004, 32'h0000_0003, rd, e);
        apb(1'b1, 12'h000, 32'h0000_0000, rd, e);
        apb(1'b0, 12'h004, 32'h0000_0000, rd, e);
        chk(rd, 32'h0000_0008);
        apb(1'b0, 12'h000, 32'h0000_0000, rd, e);
        chk(rd, 32'h0000_0B80);
    endtask
    // Fault path: address 0 is open under this word, so a deny shows the fault
    task automatic s_parity();
        logic [31:0] rd;
        logic e;
        logic [2:0] r;
        apb(1'b1, 12'h00C, 32'h0000_0001, rd, e);
        repeat (3) @(posedge clk);
        #1 chk({30'h0, parity, dev_rst}, 32'h0000_0003);
        ag_u.nvm_op(17'h0_0000, 1'b0, r);
        chk({29'h0, r}, 32'h0000_0002);
        apb(1'b0, 12'h004, 32'h0000_0000, rd, e);
        chk(rd & 32'h0000_0004, 32'h0000_0004);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk({31'h0, parity}, 32'h0000_0000);
        ag_u.nvm_op(17'h0_0000, 1'b0, r);
        chk({29'h0, r}, 32'h0000_0004);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        s_start();
        s_table();
        s_status();
        s_parity();
        conclude();
    end
endmodule
